// file: dv/test_afd_datapath_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_afd_datapath_top import afd_pkg::*;;
    // ****************************************
    // Bus signals and counters.
    // ****************************************
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int          mismatches = 0;
    int          tests_run = 0;

    // Device under test.
    afd_datapath_top #(.ADDR_W(8)) afd_datapath_top_inst (
        .mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // Free-running clock.
    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // Bus tasks.
    // ****************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready and response are sampled mid-cycle; the handshake lands on the next edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb)
        begin
            @(negedge mclk);
            ta = s_axi_awready === 1'b1;
            tw = s_axi_wready === 1'b1;
            tb = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        cmp({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr)
        begin
            @(negedge mclk);
            ta = s_axi_arready === 1'b1;
            tr = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        cmp(d, ex);
        cmp({30'h0, r}, {30'h0, er});
    endtask

    // Loads state, runs one opcode, then checks accumulators, pointer and flags.
    task automatic op(input logic [15:0] ac, od, ix, fl, oc, eac, eix, efl);
        wr(OFS_ACC, {16'h0, ac}, RESP_OKAY);
        wr(OFS_OPND, {16'h0, od}, RESP_OKAY);
        wr(OFS_INDEX, {16'h0, ix}, RESP_OKAY);
        wr(OFS_FLAGS, {16'h0, fl}, RESP_OKAY);
        wr(OFS_CTRL, {16'h0, oc}, RESP_OKAY);
        rd(OFS_ACC, {16'h0, eac}, RESP_OKAY);
        rd(OFS_INDEX, {16'h0, eix}, RESP_OKAY);
        rd(OFS_FLAGS, {16'h0, efl}, RESP_OKAY);
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset;
        rd(OFS_FLAGS, {26'h0, RST_FLAGS}, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'h5a, RESP_SLVERR);
    endtask
    task automatic t_add;
        op(16'h4800, 16'h38, 16'h0, 16'h10, 16'h8b, 16'h8000, 16'h0, 16'h3a);
    endtask
    task automatic t_adc;
        op(16'h80, 16'h7f, 16'h0, 16'h11, 16'hc9, 16'h0, 16'h0, 16'h35);
    endtask
    task automatic t_dsum;
        op(16'h8000, 16'h80, 16'h0, 16'h30, 16'hc3, 16'h0, 16'h0, 16'h37);
    endtask
    task automatic t_and;
        op(16'hf0ff, 16'h8f, 16'h0, 16'h23, 16'h84, 16'h80ff, 16'h0, 16'h29);
    endtask
    task automatic t_ptr;
        op(16'h1, 16'h0, 16'h12ff, 16'h2f, 16'h3a, 16'h1, 16'h1300, 16'h2f);
    endtask
    task automatic t_pair;
        op(16'h0f01, 16'h0, 16'h0, 16'h10, 16'h1b, 16'h1001, 16'h0, 16'h30);
        rd(OFS_CTRL, 32'h1b, RESP_OKAY);
    endtask
    // An undecoded opcode must leave all state alone and raise the illegal bit.
    task automatic t_bad;
        op(16'h1234, 16'h55, 16'h77, 16'h10, 16'h0, 16'h1234, 16'h77, 16'h10);
        rd(OFS_CTRL, 32'h100, RESP_OKAY);
    endtask

    task automatic print_verdict;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_add();
        t_adc();
        t_dsum();
        t_and();
        t_ptr();
        t_pair();
        // Second reset in mid-run; flags must return to their reset value.
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_bad();
        print_verdict();
    end
endmodule
`default_nettype wire

// file: hdl/afd_datapath_top.sv
`timescale 1ns/100ps
`default_nettype none
module afd_datapath_top
    import afd_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ********************************************************
    // Declarations.
    // ********************************************************
    afd_regs_t         st_q;
    afd_regs_t         alu_nxt;
    afd_dec_t          wr_dec;
    logic [15:0]       operand_q;
    logic [7:0]        opcode_q;
    logic              illegal_q;
    logic              aw_held_q;
    logic              w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              aw_have;
    logic              w_have;
    logic              wr_go;
    logic [7:0]        wr_word;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              ar_take;
    logic [7:0]        rd_word;
    logic              bvalid_d;
    logic              rvalid_d;
    logic              exec;
    logic              ex_q;
    afd_dec_t          ex_dec_q;
    afd_regs_t         pre_q;
    logic [15:0]       ex_m_q;
    logic [7:0]        ex_x;
    logic [7:0]        ex_r;
    logic [7:0]        ex_mb;
    logic [5:0]        ex_f;
    logic [5:0]        pre_f;

    // Merges a write into a register by byte lanes.
    function automatic logic [15:0] merge16(logic [15:0] old, logic [15:0] nw,
                                            logic [1:0] strb);
        logic [15:0] o;
        o = old;
        if (strb[0])
        begin
            o[7:0] = nw[7:0];
        end
        if (strb[1])
        begin
            o[15:8] = nw[15:8];
        end
        return o;
    endfunction

    // Reduces a byte address to its aligned word address.
    function automatic logic [7:0] word_of(logic [ADDR_W-1:0] a);
        return 8'({a[ADDR_W-1:2], 2'h0});
    endfunction

    // ********************************************************
    // Write channel handshake.
    // ********************************************************
    // A write fires once address and data are both in, from a hold or live.
    assign aw_have = aw_held_q | (s_axi_awvalid & s_axi_awready);
    assign w_have  = w_held_q | (s_axi_wvalid & s_axi_wready);
    assign wr_go   = aw_have & w_have & ~s_axi_bvalid;
    assign wr_word = word_of(aw_held_q ? aw_addr_q : s_axi_awaddr);
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    assign bvalid_d = wr_go | (s_axi_bvalid & ~s_axi_bready);
    assign exec = wr_go & (wr_word == OFS_CTRL) & wr_strb[0] & wr_dec.legal;

    // Holds whichever half of a write arrives first.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            aw_held_q <= aw_have & ~wr_go;
            w_held_q  <= w_have & ~wr_go;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Ready and response flops; readies drop until the response is taken.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~bvalid_d & ~(aw_have & ~wr_go);
            s_axi_wready  <= ~bvalid_d & ~(w_have & ~wr_go);
            s_axi_bvalid  <= bvalid_d;
            if (wr_go)
            begin
                s_axi_bresp <= (wr_word > OFS_FLAGS) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // ********************************************************
    // Datapath and programmer-visible state.
    // ********************************************************
    afd_opcode_decoder afd_opcode_decoder_inst
    (
        .opcode (wr_data[7:0]),
        .dec    (wr_dec)
    );

    afd_flag_alu afd_flag_alu_inst
    (
        .cur     (st_q),
        .dec     (wr_dec),
        .operand (operand_q),
        .nxt     (alu_nxt)
    );

    // Register writes and instruction commit share one process.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q      <= '{8'h00, 8'h00, 16'h0000, RST_FLAGS};
            operand_q <= 16'h0000;
            opcode_q  <= 8'h00;
            illegal_q <= 1'b0;
        end
        else if (wr_go)
        begin
            case (wr_word)
                OFS_CTRL:
                begin
                    if (wr_strb[0])
                    begin
                        opcode_q  <= wr_data[7:0];
                        illegal_q <= ~wr_dec.legal;
                    end
                    if (exec)
                    begin
                        st_q <= alu_nxt;                      // see RULE_17
                    end
                end
                OFS_OPND:
                begin
                    operand_q <= merge16(operand_q, wr_data[15:0], wr_strb[1:0]);
                end
                OFS_ACC:
                begin
                    {st_q.first_accumulator, st_q.second_accumulator} <=
                        merge16({st_q.first_accumulator, st_q.second_accumulator},
                                wr_data[15:0], wr_strb[1:0]);    // see RULE_15
                end
                OFS_INDEX:
                begin
                    st_q.index_pointer <=
                        merge16(st_q.index_pointer, wr_data[15:0], wr_strb[1:0]);
                end
                OFS_FLAGS:
                begin
                    if (wr_strb[0])
                    begin
                        st_q.condition_flags_register <= wr_data[5:0]; // see RULE_14
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // ********************************************************
    // Read channel.
    // ********************************************************
    assign ar_take  = s_axi_arvalid & s_axi_arready;
    assign rd_word  = word_of(s_axi_araddr);
    assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // Captures read data at the address handshake.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take)
            begin
                s_axi_rresp <= RESP_OKAY;
                case (rd_word)
                    OFS_CTRL:  s_axi_rdata <= {23'h000000, illegal_q, opcode_q};
                    OFS_OPND:  s_axi_rdata <= {16'h0000, operand_q};
                    OFS_ACC:   s_axi_rdata <= {16'h0000, st_q.first_accumulator,
                                               st_q.second_accumulator};
                    OFS_INDEX: s_axi_rdata <= {16'h0000, st_q.index_pointer};
                    OFS_FLAGS: s_axi_rdata <= {26'h0000000,
                                               st_q.condition_flags_register};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // Checks.
    // ********************************************************
    // Remembers the state before each committed instruction.
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ex_q     <= 1'b0;
            ex_dec_q <= '0;
            pre_q    <= '0;
            ex_m_q   <= 16'h0000;
        end
        else
        begin
            ex_q <= exec;
            if (exec)
            begin
                ex_dec_q <= wr_dec;
                pre_q    <= st_q;
                ex_m_q   <= operand_q;
            end
        end
    end

    assign ex_x  = ex_dec_q.sel_second ? pre_q.second_accumulator
                                       : pre_q.first_accumulator;
    assign ex_r  = ex_dec_q.sel_second ? st_q.second_accumulator
                                       : st_q.first_accumulator;
    assign ex_mb = (ex_dec_q.op == AFD_OP_PAIR_SUM) ? pre_q.second_accumulator
                                                    : ex_m_q[7:0];
    assign ex_f  = st_q.condition_flags_register;
    assign pre_f = pre_q.condition_flags_register;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    property p_ptr_sum;
        ex_q && ex_dec_q.op == AFD_OP_PTR_SUM |->
            st_q.index_pointer == 16'(pre_q.index_pointer
                                      + {8'h00, pre_q.second_accumulator});
    endproperty
    a_ptr_sum: assert property (p_ptr_sum) // see RULE_01
        else $error("pointer sum wrong");

    property p_ptr_only;
        ex_q && ex_dec_q.op == AFD_OP_PTR_SUM |->
            ex_f == pre_f && st_q.second_accumulator == pre_q.second_accumulator
            && st_q.first_accumulator == pre_q.first_accumulator;
    endproperty
    a_ptr_only: assert property (p_ptr_only) // see RULE_02
        else $error("pointer sum touched other state");

    property p_byte_sum;
        ex_q && (ex_dec_q.op == AFD_OP_ADC || ex_dec_q.op == AFD_OP_ADD
                 || ex_dec_q.op == AFD_OP_PAIR_SUM) |->
            ex_r == 8'(ex_x + ex_mb + {7'h00, (ex_dec_q.op == AFD_OP_ADC)
                                              & pre_f[FLG_C]});
    endproperty
    a_byte_sum: assert property (p_byte_sum) // see RULE_03
        else $error("byte sum wrong");

    property p_byte_flags;
        ex_q && (ex_dec_q.op == AFD_OP_ADC || ex_dec_q.op == AFD_OP_ADD
                 || ex_dec_q.op == AFD_OP_PAIR_SUM) |->
            ex_f[FLG_H] == (ex_x[3] & ex_mb[3] | ex_mb[3] & ~ex_r[3] | ~ex_r[3] & ex_x[3])
            && ex_f[FLG_C] == (ex_x[7] & ex_mb[7] | ex_mb[7] & ~ex_r[7] | ~ex_r[7] & ex_x[7])
            && ex_f[FLG_V] == (ex_x[7] & ex_mb[7] & ~ex_r[7] | ~ex_x[7] & ~ex_mb[7] & ex_r[7]);
    endproperty
    a_byte_flags: assert property (p_byte_flags) // see RULE_05
        else $error("byte add flags wrong");

    property p_neg_zero;
        ex_q && ex_dec_q.op != AFD_OP_PTR_SUM && ex_dec_q.op != AFD_OP_DSUM |->
            ex_f[FLG_N] == ex_r[7] && ex_f[FLG_Z] == (ex_r == 8'h00);
    endproperty
    a_neg_zero: assert property (p_neg_zero) // see RULE_06
        else $error("negative or zero flag wrong");

    property p_dsum;
        ex_q && ex_dec_q.op == AFD_OP_DSUM |->
            {st_q.first_accumulator, st_q.second_accumulator} ==
                16'({pre_q.first_accumulator, pre_q.second_accumulator}
                    + {ex_m_q[7:0], ex_m_q[15:8]})
            && ex_f[FLG_Z] == ({st_q.first_accumulator, st_q.second_accumulator}
                               == 16'h0000)
            && ex_f[FLG_H] == pre_f[FLG_H];
    endproperty
    a_dsum: assert property (p_dsum) // see RULE_10
        else $error("double add wrong");

    property p_and;
        ex_q && ex_dec_q.op == AFD_OP_AND |->
            ex_r == (ex_x & ex_m_q[7:0]) && !ex_f[FLG_V]
            && ex_f[FLG_C] == pre_f[FLG_C] && ex_f[FLG_H] == pre_f[FLG_H];
    endproperty
    a_and: assert property (p_and) // see RULE_12
        else $error("and result or flags wrong");

    property p_mask_kept;
        ex_q |-> ex_f[FLG_I] == pre_f[FLG_I];
    endproperty
    a_mask_kept: assert property (p_mask_kept) // see RULE_16
        else $error("interrupt mask changed");

    property p_resp_holds;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_resp_holds: assert property (p_resp_holds)
        else $error("write response dropped early");

    property p_resp_next;
        wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_resp_next: assert property (p_resp_next)
        else $error("write response or readies wrong after a write");

    c_dsum: cover property (ex_q && ex_dec_q.op == AFD_OP_DSUM);
    c_adc_carry: cover property (ex_q && ex_dec_q.op == AFD_OP_ADC && pre_f[FLG_C]);
    c_ptr_carry: cover property (ex_q && ex_dec_q.op == AFD_OP_PTR_SUM
                                 && st_q.index_pointer[15:8] != pre_q.index_pointer[15:8]);

endmodule
`default_nettype wire

// file: hdl/afd_flag_alu.sv
`timescale 1ns/100ps
`default_nettype none
module afd_flag_alu
    import afd_pkg::*;
(
    input  wire afd_regs_t   cur,
    input  wire afd_dec_t    dec,
    input  wire logic [15:0] operand,
    output afd_regs_t        nxt
);

    // Byte flags after an add; the mask bit passes through.
    function automatic logic [5:0] add_flags(logic [7:0] x, logic [7:0] m,
                                             logic [7:0] r, logic [5:0] f);
        logic [5:0] o;
        o = f;                                                // see RULE_16
        o[FLG_H] = x[3] & m[3] | m[3] & ~r[3] | ~r[3] & x[3];   // see RULE_05
        o[FLG_N] = r[7];                                      // see RULE_06
        o[FLG_Z] = (r == 8'h00);                              // see RULE_07
        o[FLG_V] = x[7] & m[7] & ~r[7] | ~x[7] & ~m[7] & r[7]; // see RULE_08
        o[FLG_C] = x[7] & m[7] | m[7] & ~r[7] | ~r[7] & x[7];   // see RULE_09
        return o;
    endfunction

    // Eight-bit sum with carry in.
    function automatic logic [7:0] add8(logic [7:0] x, logic [7:0] m, logic c);
        return 8'(x + m + {7'h00, c});
    endfunction

    // Computes the next register set for one instruction.
    always_comb
    begin
        logic [7:0]  x;
        logic [7:0]  r;
        logic [15:0] d;
        logic [15:0] m16;
        logic [15:0] s;
        logic [5:0]  f;
        nxt = cur;
        f = cur.condition_flags_register;
        x = dec.sel_second ? cur.second_accumulator : cur.first_accumulator;
        r = 8'h00;
        d = {cur.first_accumulator, cur.second_accumulator};  // see RULE_15
        m16 = {operand[7:0], operand[15:8]};                  // see RULE_10
        s = 16'(d + m16);
        case (dec.op)
            AFD_OP_PTR_SUM:                                   // see RULE_02
            begin
                nxt.index_pointer = 16'(cur.index_pointer
                                        + {8'h00, cur.second_accumulator}); // see RULE_01
            end
            AFD_OP_PAIR_SUM:
            begin
                r = add8(cur.first_accumulator, cur.second_accumulator, 1'b0);
                nxt.first_accumulator = r;                    // see RULE_13
                nxt.condition_flags_register =
                    add_flags(cur.first_accumulator, cur.second_accumulator, r, f);
            end
            AFD_OP_ADC, AFD_OP_ADD:
            begin
                r = add8(x, operand[7:0],
                         (dec.op == AFD_OP_ADC) & f[FLG_C]);  // see RULE_03
                nxt.condition_flags_register = add_flags(x, operand[7:0], r, f);
            end
            AFD_OP_AND:
            begin
                r = x & operand[7:0];                         // see RULE_12
                nxt.condition_flags_register[FLG_N] = r[7];
                nxt.condition_flags_register[FLG_Z] = (r == 8'h00);
                nxt.condition_flags_register[FLG_V] = 1'b0;
            end
            AFD_OP_DSUM:
            begin
                {nxt.first_accumulator, nxt.second_accumulator} = s;
                nxt.condition_flags_register[FLG_N] = s[15]; // see RULE_11
                nxt.condition_flags_register[FLG_Z] = (s == 16'h0000);
                nxt.condition_flags_register[FLG_V] =
                    d[15] & m16[15] & ~s[15] | ~d[15] & ~m16[15] & s[15];
                nxt.condition_flags_register[FLG_C] =
                    d[15] & m16[15] | m16[15] & ~s[15] | ~s[15] & d[15];
            end
            default:
            begin
            end
        endcase
        // Byte results go back to the chosen accumulator.
        if (dec.op == AFD_OP_ADC || dec.op == AFD_OP_ADD || dec.op == AFD_OP_AND)
        begin
            if (dec.sel_second)
            begin
                nxt.second_accumulator = r;                   // see RULE_04
            end
            else
            begin
                nxt.first_accumulator = r;
            end
        end
    end

endmodule
`default_nettype wire

// file: hdl/afd_opcode_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module afd_opcode_decoder
    import afd_pkg::*;
(
    input  wire logic [7:0] opcode,
    output afd_dec_t        dec
);

    // Splits the first opcode byte into operation, target and mode.
    always_comb
    begin
        dec = '{op: AFD_OP_NONE, sel_second: 1'b0,
                mode: AFD_IMPLIED_OPERAND_MODE, legal: 1'b0};
        if (opcode == OPC_PTR_SUM)
        begin
            dec.op = AFD_OP_PTR_SUM;                         // see RULE_17
        end
        else if (opcode == OPC_PAIR_SUM)
        begin
            dec.op = AFD_OP_PAIR_SUM;
        end
        else if (opcode[7])
        begin
            dec.sel_second = opcode[6];                      // see RULE_17
            case (opcode[5:4])
                2'h0:    dec.mode = AFD_LITERAL_OPERAND_MODE;
                2'h1:    dec.mode = AFD_DIRECT_PAGE_MODE;
                2'h2:    dec.mode = AFD_POINTER_OFFSET_MODE;
                default: dec.mode = AFD_FULL_ADDRESS_MODE;
            endcase
            case (opcode[3:0])
                LO_ADC:  dec.op = AFD_OP_ADC;
                LO_ADD:  dec.op = AFD_OP_ADD;
                LO_AND:  dec.op = AFD_OP_AND;
                LO_DSUM: dec.op = opcode[6] ? AFD_OP_DSUM : AFD_OP_NONE;
                default: dec.op = AFD_OP_NONE;
            endcase
        end
        dec.legal = (dec.op != AFD_OP_NONE);
    end

endmodule
`default_nettype wire

// file: hdl/afd_pkg.sv
// What this block does
// RULE_01 - Pointer plus zero-extended second accumulator, full carry.
// RULE_02 - Pointer sum changes only the pointer.
// RULE_03 - Carry add: accumulator plus operand plus carry.
// RULE_04 - Plain add: accumulator plus operand, no carry.
// RULE_05 - Byte adds set half-carry from bit three.
// RULE_06 - Byte add and AND: negative is bit seven.
// RULE_07 - Zero set only when all result bits clear.
// RULE_08 - Adds set overflow on two's-complement sign overflow.
// RULE_09 - Adds set carry out of the top bit.
// RULE_10 - Double add: byte M high, next byte low.
// RULE_11 - Double add keeps half-carry and mask; top-bit flags.
// RULE_12 - AND stores conjunction, clears overflow, keeps others.
// RULE_13 - Pair sum adds second into first, byte flags.
// RULE_14 - Flags: carry0 overflow1 zero2 negative3 mask4 halfcarry5.
// RULE_15 - Double accumulator is first high, second low.
// RULE_16 - Interrupt mask never changed by this group.
// RULE_17 - Opcode decodes operation, accumulator and addressing mode.
`default_nettype none
package afd_pkg;

    // ********************************************************
    // Register map and reset values.
    // ********************************************************
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_OPND  = 8'h04;
    localparam logic [7:0] OFS_ACC   = 8'h08;
    localparam logic [7:0] OFS_INDEX = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [5:0] RST_FLAGS = 6'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************
    // Flag positions and opcode codes.
    // ********************************************************
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_I = 4;
    localparam int FLG_H = 5;
    localparam logic [7:0] OPC_PTR_SUM  = 8'h3a;
    localparam logic [7:0] OPC_PAIR_SUM = 8'h1b;
    localparam logic [3:0] LO_ADC  = 4'h9;
    localparam logic [3:0] LO_ADD  = 4'hb;
    localparam logic [3:0] LO_AND  = 4'h4;
    localparam logic [3:0] LO_DSUM = 4'h3;

    // ********************************************************
    // Types.
    // ********************************************************
    typedef enum logic [2:0] {
        AFD_OP_NONE, AFD_OP_PTR_SUM, AFD_OP_PAIR_SUM, AFD_OP_ADC,
        AFD_OP_ADD, AFD_OP_DSUM, AFD_OP_AND
    } afd_op_t;

    typedef enum logic [2:0] {
        AFD_IMPLIED_OPERAND_MODE, AFD_LITERAL_OPERAND_MODE,
        AFD_DIRECT_PAGE_MODE, AFD_POINTER_OFFSET_MODE, AFD_FULL_ADDRESS_MODE
    } afd_mode_t;

    typedef struct packed {
        afd_op_t   op;
        logic      sel_second;
        afd_mode_t mode;
        logic      legal;
    } afd_dec_t;

    typedef struct packed {
        logic [7:0]  first_accumulator;
        logic [7:0]  second_accumulator;
        logic [15:0] index_pointer;
        logic [5:0]  condition_flags_register;
    } afd_regs_t;

endpackage
`default_nettype wire
